// ===== scs_defs.vh
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// Register byte addresses
`define ADDR_CMD 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_IRQ_EN0 12'h008
`define ADDR_IRQ_EN1 12'h00C
`define ADDR_IRQ_EN2 12'h010
`define ADDR_FRAME_IE 12'h014
`define ADDR_TX_LOW 12'h018
`define ADDR_TX_HIGH 12'h01C
`define ADDR_RX_THR 12'h020
`define ADDR_CTRL 12'h024
`define ADDR_STATUS3 12'h028
// Commands
`define CMD_NOP 8'h00
`define CMD_FORCE_CRC 8'h18
`define CMD_CHAN_RESET 8'h21
`define CMD_SEARCH 8'h31
// Primary status bit positions
`define ST_TX_SUM 7
`define ST_RX_SUM 6
`define ST_TX_RDY 1
`define ST_RX_RDY 0
// Line status one bit positions
`define L1_UNDERRUN 7
`define L1_IDLE 6
`define L1_CTS 3
// Control register fields
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define CTRL_BITSYNC 2
// Status three field
`define S3_SEARCH 0
// Reset values
`define RST_BYTE 8'h00
`define RST_THR 5'h00
`define RST_HIGH_THR 5'h1F
// Timing
`define CRC_DELAY_CYCLES 15
// Engine count at completion, giving the 15-cycle status latency
`define CRC_DONE_CNT 4'hD
`define CRC_POLY 16'h1021
`define CRC_SEED 16'hFFFF
`define CRC_GOOD 16'h0000
`endif

// ===== crc_byte_engine.v
`timescale 1ns/1ps
`include "scs_defs.vh"
module crc_byte_engine (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire clear_in,
  input wire start_in,
  input wire [7:0] data_in,
  input wire [15:0] crc_in,
  output reg busy_out,
  output reg done_out,
  output reg [15:0] crc_out
);
  reg [3:0] cnt_reg;
  reg [7:0] data_reg;
  wire fb;
  assign fb = crc_out[15] ^ data_reg[7];
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 4'h0;
      data_reg <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      crc_out <= 16'h0000;
    end else if (clear_in) begin
      cnt_reg <= 4'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        busy_out <= 1'b1;
        cnt_reg <= 4'h0;
        data_reg <= data_in;
        crc_out <= crc_in;
      end else if (busy_out) begin
        // One bit per cycle, then pad cycles to the fixed latency
        if (cnt_reg < 4'h8) begin
          crc_out <= fb ? ({crc_out[14:0], 1'b0} ^ `CRC_POLY) : {crc_out[14:0], 1'b0};
          data_reg <= {data_reg[6:0], 1'b0};
        end
        if (cnt_reg == `CRC_DONE_CNT) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// ===== serial_channel_status_irq.v
`timescale 1ns/1ps
`include "scs_defs.vh"
// Functional notes
// - Command 18H starts CRC over the receive delay byte at once.
// - CRC error status appears 15 cycles after command, held until next byte.
// - Command 21H resets channel registers, disables TX/RX, empties buffers.
// - Command 31H puts clock recovery loop in search, sets search indicator.
// - Command 00H changes nothing.
// - Primary status cleared by reset, channel reset, system stop; raises interrupt.
// - TX summary is OR of underrun, idle, CTS change, each with enable.
// - TX interrupt when TX summary and its enable both set.
// - RX summary is OR of all enabled receive conditions.
// - RX interrupt when RX summary and its enable both set.
// - Frame-end-read term needs enable, frame ended, last character read.
// - Primary status bits 5 to 2 read zero.
// - TX ready sets at count at or below low threshold when enabled.
// - TX ready clears at count reaching high threshold plus one.
// - TX ready forced low when TX disabled or on underrun.
// - TX ready raises DMA request and enabled interrupt.
// - High threshold 31 lets TX ready assert with 31 bytes queued.
// - RX ready sets at threshold plus one, or FRAME_END data in bit sync.
// - RX ready stays set until receive buffer is empty.
// - RX ready raises DMA request and enabled interrupt.
module serial_channel_status_irq #(
  parameter FIFO_CNT_W = 6
) (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire system_stop_in,
  input wire [7:0] line_status_one_in,
  input wire [7:0] receive_status_two_in,
  input wire frame_end_read_in,
  input wire [7:0] rx_delay_byte_in,
  input wire [15:0] rx_crc_acc_in,
  input wire rx_byte_enter_in,
  input wire rx_eom_enter_in,
  input wire [FIFO_CNT_W-1:0] tx_count_in,
  input wire [FIFO_CNT_W-1:0] rx_count_in,
  output reg tx_irq_out,
  output reg rx_irq_out,
  output reg tx_rdy_irq_out,
  output reg rx_rdy_irq_out,
  output reg tx_dma_req_out,
  output reg rx_dma_req_out,
  output reg crc_fail_out,
  output reg chan_reset_out,
  output reg search_start_out,
  output reg tx_enable_out,
  output reg rx_enable_out
);
  //--------------------------------------------------------
  // Registers
  //--------------------------------------------------------
  reg [7:0] irq_enable_zero_reg;
  reg [7:0] irq_enable_one_reg;
  reg [7:0] irq_enable_two_reg;
  reg [7:0] frame_irq_enable_reg;
  reg [4:0] tx_low_threshold_reg;
  reg [4:0] tx_high_threshold_reg;
  reg [4:0] rx_threshold_reg;
  reg [2:0] ctrl_reg;
  reg [7:0] status_three_reg;
  reg tx_fifo_ready_reg;
  reg rx_fifo_ready_reg;
  reg tx_summary_flag_reg;
  reg rx_summary_flag_reg;
  reg crc_fail_reg;
  reg [7:0] channel_primary_status;
  reg [31:0] rdata_next;
  reg addr_ok;
  wire wr_en;
  wire rd_en;
  wire chan_clear;
  wire cmd_wr;
  wire crc_done;
  wire [15:0] crc_value;
  wire tx_summary_next;
  wire rx_summary_next;
  wire [FIFO_CNT_W-1:0] tx_low_ext;
  wire [FIFO_CNT_W-1:0] tx_high_ext;
  wire [FIFO_CNT_W-1:0] rx_thr_ext;
  wire wr_irq_en0;
  wire wr_irq_en1;
  wire wr_irq_en2;
  wire wr_frame_ie;
  wire wr_tx_low;
  wire wr_tx_high;
  wire wr_rx_thr;
  wire wr_ctrl;
  wire cmd_force_crc;
  wire cmd_chan_reset;
  wire cmd_search;

  assign wr_en = psel_in & penable_in & pwrite_in & pready_out;
  assign rd_en = psel_in & ~penable_in & ~pwrite_in;
  assign cmd_wr = wr_en & (paddr_in == `ADDR_CMD);
  // Channel reset command or system stop clears channel state
  assign chan_clear = cmd_chan_reset | system_stop_in;
  assign tx_low_ext = {{(FIFO_CNT_W-5){1'b0}}, tx_low_threshold_reg};
  assign tx_high_ext = {{(FIFO_CNT_W-5){1'b0}}, tx_high_threshold_reg};
  assign rx_thr_ext = {{(FIFO_CNT_W-5){1'b0}}, rx_threshold_reg};

  //--------------------------------------------------------
  // Write strobes and command decode
  //--------------------------------------------------------
  // Status and status three get no strobe, so writes there fall away
  assign wr_irq_en0 = wr_en & (paddr_in == `ADDR_IRQ_EN0);
  assign wr_irq_en1 = wr_en & (paddr_in == `ADDR_IRQ_EN1);
  assign wr_irq_en2 = wr_en & (paddr_in == `ADDR_IRQ_EN2);
  assign wr_frame_ie = wr_en & (paddr_in == `ADDR_FRAME_IE);
  assign wr_tx_low = wr_en & (paddr_in == `ADDR_TX_LOW);
  assign wr_tx_high = wr_en & (paddr_in == `ADDR_TX_HIGH);
  assign wr_rx_thr = wr_en & (paddr_in == `ADDR_RX_THR);
  assign wr_ctrl = wr_en & (paddr_in == `ADDR_CTRL);
  assign cmd_force_crc = cmd_wr & (pwdata_in[7:0] == `CMD_FORCE_CRC);
  assign cmd_chan_reset = cmd_wr & (pwdata_in[7:0] == `CMD_CHAN_RESET);
  assign cmd_search = cmd_wr & (pwdata_in[7:0] == `CMD_SEARCH);
  // No-op and unknown codes decode to nothing; TX and RX carry on

  //--------------------------------------------------------
  // Forced CRC engine
  //--------------------------------------------------------
  crc_byte_engine u_crc (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .clear_in(chan_clear),
    .start_in(cmd_force_crc),
    .data_in(rx_delay_byte_in),
    .crc_in(rx_crc_acc_in),
    .busy_out(),
    .done_out(crc_done),
    .crc_out(crc_value)
  );

  //--------------------------------------------------------
  // Summary terms
  //--------------------------------------------------------
  assign tx_summary_next =
    |(line_status_one_in & irq_enable_one_reg &
      ((8'h01 << `L1_UNDERRUN) | (8'h01 << `L1_IDLE) | (8'h01 << `L1_CTS)));
  assign rx_summary_next =
    (|(line_status_one_in & irq_enable_one_reg & 8'h37)) |
    (|({receive_status_two_in[7:3], receive_status_two_in[2] | crc_fail_reg, 2'b00} &
       irq_enable_two_reg)) |
    (frame_end_read_in & frame_irq_enable_reg[7]);

  //--------------------------------------------------------
  // APB slave
  //--------------------------------------------------------
  always @* begin
    addr_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr_in)
      `ADDR_CMD: rdata_next = 32'h0000_0000;
      `ADDR_STATUS: rdata_next = {24'h000000, channel_primary_status & 8'hC3};
      `ADDR_IRQ_EN0: rdata_next = {24'h000000, irq_enable_zero_reg};
      `ADDR_IRQ_EN1: rdata_next = {24'h000000, irq_enable_one_reg};
      `ADDR_IRQ_EN2: rdata_next = {24'h000000, irq_enable_two_reg};
      `ADDR_FRAME_IE: rdata_next = {24'h000000, frame_irq_enable_reg};
      `ADDR_TX_LOW: rdata_next = {27'h0000000, tx_low_threshold_reg};
      `ADDR_TX_HIGH: rdata_next = {27'h0000000, tx_high_threshold_reg};
      `ADDR_RX_THR: rdata_next = {27'h0000000, rx_threshold_reg};
      `ADDR_CTRL: rdata_next = {29'h00000000, ctrl_reg};
      `ADDR_STATUS3: rdata_next = {24'h000000, status_three_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      // One wait state: ready in the second access cycle
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
      if (rd_en) begin
        prdata_out <= addr_ok ? rdata_next : 32'h0000_0000;
      end
    end
  end

  //--------------------------------------------------------
  // Software registers
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_enable_zero_reg <= `RST_BYTE;
      irq_enable_one_reg <= `RST_BYTE;
      irq_enable_two_reg <= `RST_BYTE;
      frame_irq_enable_reg <= `RST_BYTE;
      tx_low_threshold_reg <= `RST_THR;
      tx_high_threshold_reg <= `RST_HIGH_THR;
      rx_threshold_reg <= `RST_THR;
      ctrl_reg <= 3'b000;
      status_three_reg <= `RST_BYTE;
    end else if (chan_clear) begin
      irq_enable_zero_reg <= `RST_BYTE;
      irq_enable_one_reg <= `RST_BYTE;
      irq_enable_two_reg <= `RST_BYTE;
      frame_irq_enable_reg <= `RST_BYTE;
      tx_low_threshold_reg <= `RST_THR;
      tx_high_threshold_reg <= `RST_HIGH_THR;
      rx_threshold_reg <= `RST_THR;
      ctrl_reg <= 3'b000;
      status_three_reg <= `RST_BYTE;
    end else begin
      if (wr_irq_en0) begin
        irq_enable_zero_reg <= pwdata_in[7:0];
      end
      if (wr_irq_en1) begin
        irq_enable_one_reg <= pwdata_in[7:0];
      end
      if (wr_irq_en2) begin
        irq_enable_two_reg <= pwdata_in[7:0];
      end
      if (wr_frame_ie) begin
        frame_irq_enable_reg <= pwdata_in[7:0];
      end
      if (wr_tx_low) begin
        tx_low_threshold_reg <= pwdata_in[4:0];
      end
      if (wr_tx_high) begin
        tx_high_threshold_reg <= pwdata_in[4:0];
      end
      if (wr_rx_thr) begin
        rx_threshold_reg <= pwdata_in[4:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_in[2:0];
      end
      if (cmd_search) begin
        status_three_reg[`S3_SEARCH] <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------
  // Summary flags
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_summary_flag_reg <= 1'b0;
      rx_summary_flag_reg <= 1'b0;
    end else if (chan_clear) begin
      tx_summary_flag_reg <= 1'b0;
      rx_summary_flag_reg <= 1'b0;
    end else begin
      tx_summary_flag_reg <= tx_summary_next;
      rx_summary_flag_reg <= rx_summary_next;
    end
  end

  //--------------------------------------------------------
  // Forced CRC result
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      crc_fail_reg <= 1'b0;
    end else if (chan_clear) begin
      crc_fail_reg <= 1'b0;
    end else if (crc_done) begin
      // Result wins over a byte entering in the same cycle
      crc_fail_reg <= (crc_value != `CRC_GOOD);
    end else if (rx_byte_enter_in) begin
      crc_fail_reg <= 1'b0;
    end
  end

  //--------------------------------------------------------
  // TX ready hysteresis
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_fifo_ready_reg <= 1'b0;
    end else if (chan_clear) begin
      tx_fifo_ready_reg <= 1'b0;
    end else if (!ctrl_reg[`CTRL_TX_EN] || line_status_one_in[`L1_UNDERRUN]) begin
      tx_fifo_ready_reg <= 1'b0;
    end else if (tx_count_in <= tx_low_ext) begin
      tx_fifo_ready_reg <= 1'b1;
    end else if (tx_count_in >= tx_high_ext + 1'b1) begin
      // Count is one bit wider than the threshold, so 31 plus one fits
      tx_fifo_ready_reg <= 1'b0;
    end
  end

  //--------------------------------------------------------
  // RX ready
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_fifo_ready_reg <= 1'b0;
    end else if (chan_clear) begin
      rx_fifo_ready_reg <= 1'b0;
    end else if ((rx_count_in >= rx_thr_ext + 1'b1) ||
                 (ctrl_reg[`CTRL_BITSYNC] && rx_eom_enter_in)) begin
      // Set wins over the empty clear
      rx_fifo_ready_reg <= 1'b1;
    end else if (rx_count_in == {FIFO_CNT_W{1'b0}}) begin
      rx_fifo_ready_reg <= 1'b0;
    end
  end

  //--------------------------------------------------------
  // Primary status
  //--------------------------------------------------------
  always @* begin
    channel_primary_status = {tx_summary_flag_reg, rx_summary_flag_reg, 4'h0,
                              tx_fifo_ready_reg, rx_fifo_ready_reg};
  end

  //--------------------------------------------------------
  // Request outputs
  //--------------------------------------------------------
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
      tx_rdy_irq_out <= 1'b0;
      rx_rdy_irq_out <= 1'b0;
      tx_dma_req_out <= 1'b0;
      rx_dma_req_out <= 1'b0;
      crc_fail_out <= 1'b0;
      chan_reset_out <= 1'b0;
      search_start_out <= 1'b0;
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
    end else begin
      tx_irq_out <= tx_summary_flag_reg & irq_enable_zero_reg[`ST_TX_SUM];
      rx_irq_out <= rx_summary_flag_reg & irq_enable_zero_reg[`ST_RX_SUM];
      tx_rdy_irq_out <= tx_fifo_ready_reg & irq_enable_zero_reg[`ST_TX_RDY];
      rx_rdy_irq_out <= rx_fifo_ready_reg & irq_enable_zero_reg[`ST_RX_RDY];
      tx_dma_req_out <= tx_fifo_ready_reg;
      rx_dma_req_out <= rx_fifo_ready_reg;
      crc_fail_out <= crc_fail_reg;
      chan_reset_out <= chan_clear;
      search_start_out <= cmd_search;
      tx_enable_out <= ctrl_reg[`CTRL_TX_EN];
      rx_enable_out <= ctrl_reg[`CTRL_RX_EN];
    end
  end
endmodule

// ===== scs_props.sv
`timescale 1ns/1ps
module scs_props #(
  parameter FIFO_CNT_W = 6
) (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire system_stop_in,
  input wire rx_byte_enter_in,
  input wire rx_eom_enter_in,
  input wire [FIFO_CNT_W-1:0] tx_count_in,
  input wire [FIFO_CNT_W-1:0] rx_count_in,
  input wire tx_dma_req_out,
  input wire rx_dma_req_out,
  input wire crc_fail_out,
  input wire chan_reset_out,
  input wire search_start_out,
  input wire tx_enable_out
);
  wire cmd_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000;
  wire cmd_crc = cmd_wr && pwdata_in[7:0] == 8'h18;
  wire cmd_rst = cmd_wr && pwdata_in[7:0] == 8'h21;
  wire cmd_search_indicator = cmd_wr && pwdata_in[7:0] == 8'h31;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  a_crc_fail_delay: assert property ($rose(crc_fail_out) |-> $past(cmd_crc, 17))
    else $error("crc fail did not follow forced check by 17 cycles");
  a_crc_byte_clear: assert property (rx_byte_enter_in |=> ##1 !crc_fail_out)
    else $error("crc fail held after new byte");
  a_chan_reset_cmd: assert property (cmd_rst |-> ##[1:2] chan_reset_out)
    else $error("channel reset pulse missing");
  a_search_cmd: assert property (cmd_search_indicator |-> ##[1:2] search_start_out)
    else $error("search pulse missing");
  a_tx_off_quiet: assert property (!tx_enable_out [*2] |=> !tx_dma_req_out)
    else $error("tx request while transmitter disabled");
  a_tx_full_quiet: assert property ((tx_count_in >= 32) [*2] |=> !tx_dma_req_out)
    else $error("tx request above high level");
  a_rx_empty_quiet: assert property ((rx_count_in == 0 && !rx_eom_enter_in) [*2]
    |=> !rx_dma_req_out)
    else $error("rx request with empty buffer");
  a_stop_clears: assert property (system_stop_in [*2] |=> !(tx_dma_req_out || rx_dma_req_out))
    else $error("request during system stop");
endmodule
bind serial_channel_status_irq scs_props #(.FIFO_CNT_W(FIFO_CNT_W)) u_props (
  .clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .pready_out(pready_out),
  .system_stop_in(system_stop_in),
  .rx_byte_enter_in(rx_byte_enter_in),
  .rx_eom_enter_in(rx_eom_enter_in),
  .tx_count_in(tx_count_in),
  .rx_count_in(rx_count_in),
  .tx_dma_req_out(tx_dma_req_out),
  .rx_dma_req_out(rx_dma_req_out),
  .crc_fail_out(crc_fail_out),
  .chan_reset_out(chan_reset_out),
  .search_start_out(search_start_out),
  .tx_enable_out(tx_enable_out)
);

// ===== dma_fill_model.sv
`timescale 1ns/1ps
module dma_fill_model (
  input wire clk_sys_in,
  input wire rst_b_in,
  input wire run_in,
  input wire tx_dma_req_in,
  output logic [5:0] tx_count_out
);
  // Fills while requested, drains one byte a cycle when idle
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_count_out <= 6'h00;
    end else if (!run_in && tx_count_out != 6'h00) begin
      tx_count_out <= tx_count_out - 6'h01;
    end else if (run_in && tx_dma_req_in && tx_count_out != 6'h3F) begin
      tx_count_out <= tx_count_out + 6'h01;
    end
  end
endmodule

// ===== serial_channel_status_irq_test.sv
`timescale 1ns/1ps
`include "scs_defs.vh"
module serial_channel_status_irq_test;
  logic clk_sys_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, run = 0;
  logic system_stop_in = 0, frame_end_read_in = 0, rx_byte_enter_in = 0, rx_eom_enter_in = 0;
  logic pready_out, pslverr_out, tx_irq_out, rx_irq_out, tx_rdy_irq_out, rx_rdy_irq_out;
  logic tx_dma_req_out, rx_dma_req_out, crc_fail_out, chan_reset_out, search_start_out;
  logic tx_enable_out, rx_enable_out, serr;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdata;
  logic [7:0] line_status_one_in = 8'h00, receive_status_two_in = 8'h00, rx_delay_byte_in = 8'h00;
  logic [15:0] rx_crc_acc_in = 16'h0000;
  logic [5:0] tx_count_in, rx_count_in = 6'h00;
  int fail_count = 0, n_checks = 0, cycles = 0, i;
  serial_channel_status_irq #(.FIFO_CNT_W(6)) dut (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .system_stop_in(system_stop_in),
    .line_status_one_in(line_status_one_in),
    .receive_status_two_in(receive_status_two_in),
    .frame_end_read_in(frame_end_read_in),
    .rx_delay_byte_in(rx_delay_byte_in),
    .rx_crc_acc_in(rx_crc_acc_in),
    .rx_byte_enter_in(rx_byte_enter_in),
    .rx_eom_enter_in(rx_eom_enter_in),
    .tx_count_in(tx_count_in),
    .rx_count_in(rx_count_in),
    .tx_irq_out(tx_irq_out),
    .rx_irq_out(rx_irq_out),
    .tx_rdy_irq_out(tx_rdy_irq_out),
    .rx_rdy_irq_out(rx_rdy_irq_out),
    .tx_dma_req_out(tx_dma_req_out),
    .rx_dma_req_out(rx_dma_req_out),
    .crc_fail_out(crc_fail_out),
    .chan_reset_out(chan_reset_out),
    .search_start_out(search_start_out),
    .tx_enable_out(tx_enable_out),
    .rx_enable_out(rx_enable_out)
  );
  dma_fill_model far_end (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .run_in(run),
    .tx_dma_req_in(tx_dma_req_out), .tx_count_out(tx_count_in));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    rdata = prdata_out;
    serr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task wait_tx(input logic lvl);
    int n;
    n = 0;
    while (tx_dma_req_out !== lvl && n < 300) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk(tx_dma_req_out, lvl);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(`ADDR_TX_HIGH, 32'h1F);
    rd(`ADDR_STATUS, 32'h0);
    rd(12'h0FC, 32'h0);
    chk(serr, 1'b1);
    wr(`ADDR_IRQ_EN0, 32'hC3);
    wr(`ADDR_IRQ_EN1, 32'hFF);
    wr(`ADDR_IRQ_EN2, 32'hFC);
    wr(`ADDR_FRAME_IE, 32'h80);
    for (i = 0; i < 8; i++) begin
      line_status_one_in <= 8'h01 << i;
      cyc(3);
      chk(tx_irq_out, (8'hC8 >> i) & 8'h01);
      chk(rx_irq_out, (8'h37 >> i) & 8'h01);
    end
    line_status_one_in <= 8'h00;
    for (i = 2; i < 8; i++) begin
      receive_status_two_in <= 8'h01 << i;
      cyc(3);
      chk(rx_irq_out, 1'b1);
    end
    receive_status_two_in <= 8'h00;
    frame_end_read_in <= 1'b1;
    cyc(3);
    chk(rx_irq_out, 1'b1);
    wr(`ADDR_FRAME_IE, 32'h0);
    cyc(3);
    chk(rx_irq_out, 1'b0);
    line_status_one_in <= 8'hC8;
    wr(`ADDR_IRQ_EN1, 32'h0);
    cyc(3);
    chk(tx_irq_out, 1'b0);
    wr(`ADDR_IRQ_EN1, 32'hFF);
    rd(`ADDR_STATUS, 32'h80);
    wr(`ADDR_STATUS, 32'hFF);
    rd(`ADDR_STATUS, 32'h80);
    system_stop_in <= 1'b1;
    cyc(3);
    chk(tx_irq_out, 1'b0);
    system_stop_in <= 1'b0;
    line_status_one_in <= 8'h00;
    $display("summary tests done");
    wr(`ADDR_IRQ_EN0, 32'hC3);
    wr(`ADDR_TX_LOW, 32'h4);
    wr(`ADDR_CTRL, 32'h1);
    run <= 1'b1;
    wait_tx(1'b1);
    wait_tx(1'b0);
    chk(tx_count_in, 6'h22);
    rd(`ADDR_STATUS, 32'h0);
    run <= 1'b0;
    wait_tx(1'b1);
    chk(tx_count_in, 6'h02);
    chk(tx_rdy_irq_out, 1'b1);
    line_status_one_in <= 8'h80;
    cyc(3);
    chk(tx_dma_req_out, 1'b0);
    line_status_one_in <= 8'h00;
    wr(`ADDR_CTRL, 32'h0);
    cyc(3);
    chk(tx_dma_req_out, 1'b0);
    $display("tx ready tests done");
    wr(`ADDR_RX_THR, 32'h3);
    for (i = 0; i < 4; i++) begin
      rx_count_in <= 6'(32'h00010403 >> (8 * i));
      cyc(3);
      chk(rx_dma_req_out, (4'h6 >> i) & 4'h1);
      chk(rx_rdy_irq_out, (4'h6 >> i) & 4'h1);
    end
    for (i = 0; i < 2; i++) begin
      wr(`ADDR_CTRL, 32'h4 * i);
      rx_count_in <= 6'h01;
      rx_eom_enter_in <= 1'b1;
      cyc(1);
      rx_eom_enter_in <= 1'b0;
      cyc(3);
      chk(rx_dma_req_out, i);
      rx_count_in <= 6'h00;
      cyc(3);
      chk(rx_dma_req_out, 1'b0);
    end
    $display("rx ready tests done");
    rx_delay_byte_in <= 8'h01;
    wr(`ADDR_CMD, 32'h18);
    cyc(16);
    chk(crc_fail_out, 1'b0);
    cyc(1);
    chk(crc_fail_out, 1'b1);
    rx_byte_enter_in <= 1'b1;
    cyc(1);
    rx_byte_enter_in <= 1'b0;
    cyc(3);
    chk(crc_fail_out, 1'b0);
    rx_delay_byte_in <= 8'h00;
    wr(`ADDR_CMD, 32'h18);
    cyc(20);
    chk(crc_fail_out, 1'b0);
    $display("crc tests done");
    wr(`ADDR_CTRL, 32'h3);
    wr(`ADDR_CMD, 32'h0);
    rd(`ADDR_CTRL, 32'h3);
    chk(tx_enable_out, 1'b1);
    chk(rx_enable_out, 1'b1);
    wr(`ADDR_CMD, 32'h31);
    rd(`ADDR_STATUS3, 32'h1);
    wr(`ADDR_TX_LOW, 32'h9);
    wr(`ADDR_CMD, 32'h21);
    rd(`ADDR_CTRL, 32'h0);
    rd(`ADDR_TX_LOW, 32'h0);
    rd(`ADDR_TX_HIGH, 32'h1F);
    rd(`ADDR_STATUS3, 32'h0);
    chk(tx_enable_out, 1'b0);
    $display("command tests done");
    stop_test();
  end
endmodule
